// ### core/pax_pkg.sv
// package for the eight-bit port block: offsets, resets, carriers
package pax_pkg;
  localparam int PAX_WIDTH = 8; // lines per port
  localparam int PAX_ADDR_W = 8; // data memory address width
  // register addresses in the special-purpose region; no offsets printed
  localparam logic [7:0] PAX_OUT_ADDR = 8'h14; // port_output_data
  localparam logic [7:0] PAX_DIR_ADDR = 8'h15; // port_direction
  localparam logic [7:0] PAX_PULL_ADDR = 8'h16; // pull_high_enable
  localparam logic [7:0] PAX_WAKE_ADDR = 8'h17; // wakeup_enable
  localparam logic [7:0] PAX_REMAP_ADDR = 8'h18; // pin_remap_select
  // reset values, same for power-on and normal-mode watchdog resets
  localparam logic [7:0] PAX_OUT_RST = 8'hff;
  localparam logic [7:0] PAX_DIR_RST = 8'hff;
  localparam logic [7:0] PAX_PULL_RST = 8'h00;
  localparam logic [7:0] PAX_WAKE_RST = 8'h00;
  localparam logic [7:0] PAX_REMAP_RST = 8'h00;
  // register index codes
  typedef enum logic [2:0] {
    PAX_SEL_NONE = 3'b000,
    PAX_SEL_OUT = 3'b001,
    PAX_SEL_DIR = 3'b010,
    PAX_SEL_PULL = 3'b011,
    PAX_SEL_WAKE = 3'b100,
    PAX_SEL_REMAP = 3'b101
  } pax_sel_type;
  // data memory access from the core
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } pax_mem_req_type;
  // pin drive bundle
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
    logic [7:0] pull_en;
  } pax_pin_drive_type;
endpackage : pax_pkg

// ### core/pax_port.sv
// eight-bit general-purpose port with pull-high and wake-up control
`timescale 1ns/10ps
`default_nettype none
module pax_port
  import pax_pkg::*;
#(
  parameter int WIDTH = pax_pkg::PAX_WIDTH
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic wdt_reset_normal,
  input wire logic wdt_reset_halt,
  input wire pax_pkg::pax_mem_req_type mem_req,
  output logic [7:0] mem_rdata,
  output logic mem_hit,
  input wire logic [7:0] pin_in,
  output pax_pkg::pax_pin_drive_type pin_drive,
  output logic [7:0] remap_sel,
  output logic wake
);
  import pax_pkg::*;

  // the logic is laid out for one byte-wide port only
  if (WIDTH != PAX_WIDTH) begin : g_bad_width
    $error("pax_port: WIDTH must be 8");
  end

  // decode an address into a register index; used for reads and writes
  function automatic pax_sel_type decode(input logic [7:0] a);
    case (a)
      PAX_OUT_ADDR: decode = PAX_SEL_OUT;
      PAX_DIR_ADDR: decode = PAX_SEL_DIR;
      PAX_PULL_ADDR: decode = PAX_SEL_PULL;
      PAX_WAKE_ADDR: decode = PAX_SEL_WAKE;
      PAX_REMAP_ADDR: decode = PAX_SEL_REMAP;
      default: decode = PAX_SEL_NONE;
    endcase
  endfunction

  logic [7:0] out_reg, out_next; // output latch
  logic [7:0] dir_reg, dir_next; // one = input
  logic [7:0] pull_reg, pull_next; // pull-high enables
  logic [7:0] wake_en_reg, wake_en_next; // wake-up enables
  logic [7:0] remap_reg, remap_next; // remap selection, not decoded here
  logic [7:0] rdata_reg, rdata_next; // read data
  logic hit_reg, hit_next; // read address matched a port register
  pax_pin_drive_type drive_reg, drive_next; // registered pin drive
  pax_sel_type wsel, rsel;
  logic soft_reset; // power-on equivalent reload

  // halt-mode watchdog reset is deliberately not a term here
  assign soft_reset = rst | wdt_reset_normal;

  // next register values and read mux
  always_comb begin
    wsel = decode(mem_req.addr);
    rsel = wsel;
    out_next = out_reg;
    dir_next = dir_reg;
    pull_next = pull_reg;
    wake_en_next = wake_en_reg;
    remap_next = remap_reg;
    if (mem_req.wr) begin
      case (wsel)
        PAX_SEL_OUT: out_next = mem_req.wdata;
        PAX_SEL_DIR: dir_next = mem_req.wdata;
        PAX_SEL_PULL: pull_next = mem_req.wdata;
        PAX_SEL_WAKE: wake_en_next = mem_req.wdata;
        PAX_SEL_REMAP: remap_next = mem_req.wdata;
        default: ;
      endcase
    end
    // read: unmapped addresses return zero, hit low
    hit_next = mem_req.rd && (rsel != PAX_SEL_NONE);
    case (rsel)
      // input bits read the pin now, output bits the latch
      PAX_SEL_OUT: rdata_next = (dir_reg & pin_in)
        | (~dir_reg & out_reg);
      PAX_SEL_DIR: rdata_next = dir_reg;
      PAX_SEL_PULL: rdata_next = pull_reg;
      PAX_SEL_WAKE: rdata_next = wake_en_reg;
      PAX_SEL_REMAP: rdata_next = remap_reg;
      default: rdata_next = 8'h00;
    endcase
    if (!mem_req.rd) begin
      rdata_next = 8'h00;
    end
  end

  // pin drive follows the stored registers one cycle later
  always_comb begin
    drive_next.out = out_reg;
    drive_next.oe = ~dir_reg;
    drive_next.pull_en = pull_reg & dir_reg;
  end

  // register stage; reset wins, otherwise ce low freezes everything
  always_ff @(posedge clk) begin
    if (soft_reset) begin
      out_reg <= PAX_OUT_RST;
      dir_reg <= PAX_DIR_RST;
      pull_reg <= PAX_PULL_RST;
      wake_en_reg <= PAX_WAKE_RST;
      remap_reg <= PAX_REMAP_RST;
      rdata_reg <= 8'h00;
      hit_reg <= 1'b0;
      drive_reg <= '{out: PAX_OUT_RST, oe: ~PAX_DIR_RST, pull_en: 8'h00};
    end else if (ce) begin
      out_reg <= out_next;
      dir_reg <= dir_next;
      pull_reg <= pull_next;
      wake_en_reg <= wake_en_next;
      remap_reg <= remap_next;
      rdata_reg <= rdata_next;
      hit_reg <= hit_next;
      drive_reg <= drive_next;
    end
  end

  // falling-edge wake detection on enabled pins
  pax_wake_detect #(
    .WIDTH(WIDTH)
  ) pax_wake_detect_i (
    .clk(clk),
    .rst(soft_reset),
    .ce(ce),
    .pin_level(pin_in),
    .wake_en(wake_en_reg),
    .wake(wake)
  );

  assign mem_rdata = rdata_reg;
  assign mem_hit = hit_reg;
  assign pin_drive = drive_reg;
  assign remap_sel = remap_reg;

  // write to output latch shows on pins two edges later
  AST_OUT_WRITE: assert property (
    @(posedge clk) disable iff (soft_reset)
    ce && mem_req.wr && mem_req.addr == PAX_OUT_ADDR ##1 ce
    |=> pin_drive.out == $past(mem_req.wdata, 2))
    else $error("output write did not reach the pins");
  // a driven pin never carries the pull-high as well
  AST_PULL_INPUT_ONLY: assert property (
    @(posedge clk) disable iff (rst)
    (pin_drive.pull_en & pin_drive.oe) == 8'h00)
    else $error("pull-high on a driven pin");
  // the latch only moves on a write; a reset edge is left out, since
  // the reload lands one edge after the reset term is sampled
  AST_LATCH_HOLDS: assert property (
    @(posedge clk) disable iff (soft_reset)
    !soft_reset && !(mem_req.wr && mem_req.addr == PAX_OUT_ADDR)
    |=> $stable(out_reg))
    else $error("output latch changed without a write");
  // power-on values of all five registers
  AST_RESET_VALUES: assert property (
    @(posedge clk)
    rst |=> out_reg == 8'hff && dir_reg == 8'hff && pull_reg == 8'h00
      && wake_en_reg == 8'h00 && remap_reg == 8'h00)
    else $error("wrong reset values");
  // normal-mode watchdog reset reloads the same five values
  AST_WDT_NORMAL: assert property (
    @(posedge clk)
    wdt_reset_normal |=> out_reg == 8'hff && dir_reg == 8'hff
      && pull_reg == 8'h00 && wake_en_reg == 8'h00 && remap_reg == 8'h00)
    else $error("normal watchdog reset did not reload");
  // halted watchdog reset must not touch the port
  AST_WDT_HALT: assert property (
    @(posedge clk)
    wdt_reset_halt && !rst && !wdt_reset_normal && !mem_req.wr
    |=> $stable(dir_reg) && $stable(pull_reg) && $stable(out_reg)
      && $stable(wake_en_reg) && $stable(remap_reg))
    else $error("halted watchdog reset changed port registers");
  // output bits of a data read return the latch, whatever the pin shows
  AST_READ_OUTPUT_LATCH: assert property (
    @(posedge clk) disable iff (soft_reset)
    ce && !soft_reset && mem_req.rd && mem_req.addr == PAX_OUT_ADDR
    |=> ((mem_rdata ^ $past(out_reg)) & ~$past(dir_reg)) == 8'h00)
    else $error("output read did not return latch");
  // input bits of a data read return the pin level at the read edge
  AST_READ_INPUT_PIN: assert property (
    @(posedge clk) disable iff (soft_reset)
    ce && !soft_reset && mem_req.rd && mem_req.addr == PAX_OUT_ADDR
    |=> ((mem_rdata ^ $past(pin_in)) & $past(dir_reg)) == 8'h00
      && mem_hit)
    else $error("input read did not sample pins");
  // each pull-high bit reaches its own pin while that pin is an input
  AST_PULL_BIT: assert property (
    @(posedge clk) disable iff (soft_reset)
    ce && !soft_reset
    |=> pin_drive.pull_en == ($past(pull_reg) & $past(dir_reg)))
    else $error("pull-high enable does not follow its bit");
  // no wake while no pin is enabled
  AST_WAKE: assert property (
    @(posedge clk) disable iff (soft_reset)
    ce && wake_en_reg == 8'h00 ##1 ce && $stable(wake_en_reg) |=> !wake)
    else $error("wake with no pin enabled");
  // direction zero drives the pin, one releases it
  AST_DRIVE_DIR: assert property (
    @(posedge clk) disable iff (soft_reset)
    ce && !soft_reset |=> pin_drive.oe == ~$past(dir_reg))
    else $error("pin drive does not follow direction");
  // addresses outside the five registers answer zero with no hit
  AST_UNMAPPED_READ: assert property (
    @(posedge clk) disable iff (soft_reset)
    ce && mem_req.rd
      && (mem_req.addr < PAX_OUT_ADDR || mem_req.addr > PAX_REMAP_ADDR)
    |=> mem_rdata == 8'h00 && !mem_hit)
    else $error("unmapped read answered");
  // read data stands one enabled cycle only, so stale bytes never linger while ce is high
  AST_READ_IDLE: assert property (
    @(posedge clk) disable iff (soft_reset)
    ce && !mem_req.rd |=> mem_rdata == 8'h00 && !mem_hit)
    else $error("read data left standing");
  // remap register is exported the cycle after its write
  AST_REMAP_EXPORT: assert property (
    @(posedge clk) disable iff (soft_reset)
    ce && !soft_reset && mem_req.wr && mem_req.addr == PAX_REMAP_ADDR
    |=> remap_sel == $past(mem_req.wdata))
    else $error("remap selection not exported");
  // with ce low and no reset nothing moves, pins and read data included
  AST_CE_FREEZE: assert property (
    @(posedge clk) disable iff (soft_reset)
    !ce && !soft_reset |=> $stable(out_reg) && $stable(dir_reg)
      && $stable(pin_drive) && $stable(mem_rdata) && $stable(wake))
    else $error("state moved while clock enable was low");
endmodule // pax_port
`default_nettype wire

// ### core/pax_wake_detect.sv
// falling-edge wake detector for the port pins
`timescale 1ns/10ps
`default_nettype none
module pax_wake_detect #(
  parameter int WIDTH = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [WIDTH-1:0] pin_level,
  input wire logic [WIDTH-1:0] wake_en,
  output logic wake
);
  logic [WIDTH-1:0] prev_reg; // pin levels one cycle ago
  logic [WIDTH-1:0] prev_next;
  logic wake_reg;
  logic wake_next;

  // next values: high-to-low on an enabled pin wakes the core
  always_comb begin
    prev_next = pin_level;
    wake_next = |(prev_reg & ~pin_level & wake_en);
  end

  // prev resets high so a pin held high at reset is no edge
  always_ff @(posedge clk) begin
    if (rst) begin
      prev_reg <= {WIDTH{1'b1}};
      wake_reg <= 1'b0;
    end else if (ce) begin
      prev_reg <= prev_next;
      wake_reg <= wake_next;
    end
  end

  assign wake = wake_reg;
endmodule // pax_wake_detect
`default_nettype wire

// ### tb/pax_pin_model.sv
// pin level model of the circuitry outside the port
`timescale 1ns/10ps
`default_nettype none
module pax_pin_model
  import pax_pkg::*;
(
  input wire logic clk,
  input wire pax_pkg::pax_pin_drive_type drv,
  input wire logic [7:0] ext_val,
  input wire logic [7:0] ext_en,
  output logic [7:0] pin_in
);
  // undriven lines wander so a float never reads as a stable level
  logic [7:0] float_q = 8'h55;
  // toggle every cycle, a settled x would hide a missing pull-high
  always @(posedge clk) begin
    float_q <= ~float_q;
  end
  // resolve each line: device drive, outside drive, pull-high, float
  always_comb begin
    for (int b = 0; b < 8; b++) begin
      if (drv.oe[b]) begin
        pin_in[b] = drv.out[b];
      end else if (ext_en[b]) begin
        pin_in[b] = ext_val[b];
      end else if (drv.pull_en[b]) begin
        pin_in[b] = 1'b1;
      end else begin
        pin_in[b] = float_q[b];
      end
    end
  end
endmodule // pax_pin_model
`default_nettype wire

// ### tb/pax_port_tb.sv
// self-checking bench for the eight-bit port block
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
  error_cnt++; $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module pax_port_tb;
  import pax_pkg::*;
  logic clk, rst, ce, wdt_normal, wdt_halt, hit, wake, woke;
  pax_mem_req_type req; // core side request
  pax_pin_drive_type drv; // pin drive bundle from the port
  logic [7:0] rdata, pin_in, remap, ext_val, ext_en;
  int error_cnt = 0;
  int total_checks = 0;
  pax_port pax_port_i (.clk(clk), .rst(rst), .ce(ce),
    .wdt_reset_normal(wdt_normal), .wdt_reset_halt(wdt_halt),
    .mem_req(req), .mem_rdata(rdata), .mem_hit(hit), .pin_in(pin_in),
    .pin_drive(drv), .remap_sel(remap), .wake(wake));
  pax_pin_model pax_pin_model_i (.clk(clk), .drv(drv), .ext_val(ext_val),
    .ext_en(ext_en), .pin_in(pin_in));
  // 250 MHz clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // one write cycle, request dropped at the taking edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req <= '0;
  endtask
  // one read cycle, data checked just after the answering edge
  task automatic rd(input logic [7:0] a, input logic [7:0] e,
    input string n);
    @(posedge clk);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req <= '0;
    #1;
    `CHK(n, e, rdata)
    `CHK("hit", 1'(a >= PAX_OUT_ADDR && a <= PAX_REMAP_ADDR), hit)
  endtask
  // read all five registers in address order
  task automatic regs(input logic [39:0] e);
    for (int i = 0; i < 5; i++) begin
      rd(PAX_OUT_ADDR + 8'(i), e[39-8*i -: 8], "reg");
    end
  endtask
  task conclude;
    $display("errors %0d checks %0d", error_cnt, total_checks);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // the sequence needs about seventy cycles; cut a hang well after
  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    conclude();
  end
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    wdt_normal = 1'b0;
    wdt_halt = 1'b0;
    req = '0;
    ext_val = 8'hff;
    ext_en = 8'hff;
    woke = 1'b0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    regs(40'hff_ff_00_00_00);
    `CHK("oe", 8'h00, drv.oe)
    `CHK("pull", 8'h00, drv.pull_en)
    // upper nibble stays input (one), lower nibble driven (zero)
    wr(PAX_DIR_ADDR, 8'hf0);
    wr(PAX_OUT_ADDR, 8'ha5);
    wr(PAX_PULL_ADDR, 8'h3c);
    wr(PAX_REMAP_ADDR, 8'h5a);
    wr(PAX_WAKE_ADDR, 8'h80);
    ext_en <= 8'hc0;
    ext_val <= 8'hc0;
    rd(8'h20, 8'h00, "unmapped");
    `CHK("oe", 8'h0f, drv.oe)
    `CHK("out", 8'ha5, drv.out)
    `CHK("pull", 8'h30, drv.pull_en)
    `CHK("remap", 8'h5a, remap)
    regs(40'hf5_f0_3c_80_5a);
    // pin 7 falls with its wake enabled
    @(posedge clk);
    ext_val <= 8'h40;
    repeat (4) begin
      @(posedge clk);
      #1;
      if (wake === 1'b1) woke = 1'b1;
    end
    `CHK("wake", 1'b1, woke)
    // a write offered while the clock enable is low must be lost
    @(posedge clk);
    ce <= 1'b0;
    wr(PAX_OUT_ADDR, 8'h00);
    ce <= 1'b1;
    @(posedge clk);
    wdt_halt <= 1'b1;
    @(posedge clk);
    wdt_halt <= 1'b0;
    regs(40'h75_f0_3c_80_5a);
    `CHK("out", 8'ha5, drv.out)
    @(posedge clk);
    ext_val <= 8'hff;
    ext_en <= 8'hff;
    wdt_normal <= 1'b1;
    @(posedge clk);
    wdt_normal <= 1'b0;
    regs(40'hff_ff_00_00_00);
    `CHK("oe", 8'h00, drv.oe)
    conclude();
  end
endmodule // pax_port_tb
`default_nettype wire
